// [src/gdc_gate_drive_config.v]
// gate drive configuration register bank with dead-time, limit and window outputs
// ----------------------------------------------------------------
// Notes on behaviour
// R1 - bits 7:6 of drive strength: boost high-side drive, 00 fastest to 11 slowest
// R2 - bits 5:4: buck high-side drive strength, same four-step coding, reset zero
// R3 - bits 3:2: boost low-side drive strength, code zero fastest, reset zero
// R4 - bits 1:0: buck low-side drive strength, code zero fastest, reset zero
// R5 - dead-time bits 3:2 set boost-leg dead time 45/75/105/135 ns, reset 45
// R6 - dead-time bits 1:0 set buck-leg dead time, same coding, reset shortest
// R7 - discharge bits 7:6 limit reverse current 20/15/10/5 A, reset 20 A
// R8 - discharge bit 1 enables fast transient, reverse mode only, resets enabled
// R9 - switching stops whenever input is outside the undervoltage/overvoltage window
// R10 - feedback reference defaults to 1.536 V, software setting may replace it
// R11 - software configures tracking control and charging parameters for solar use; this bank holds no tracking or charging registers
// R12 - read-only id: part number bits 6:3, revision bits 2:0, bit 7 zero
// R13 - reserved bits read zero and writes to them are ignored
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "gdc_regs.vh"

module gdc_gate_drive_config #(
  parameter [3:0] PART_NUMBER = 4'h5, // arbitrary value, not a real part code
  parameter [2:0] REVISION = 3'h1 // arbitrary value, not a real revision
) (
  input wire clk_i,
  input wire reset_i,
  input wire register_reset_i,
  input wire [7:0] addr_i,
  input wire write_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  input wire reverse_mode_i,
  input wire input_undervoltage_sense_i,
  input wire input_overvoltage_sense_i,
  input wire feedback_reference_valid_i,
  input wire [15:0] feedback_reference_setting_i,
  output reg [1:0] boost_high_side_drive_strength_o,
  output reg [1:0] buck_high_side_drive_strength_o,
  output reg [1:0] boost_low_side_drive_strength_o,
  output reg [1:0] buck_low_side_drive_strength_o,
  output reg [7:0] boost_dead_time_cycles_o,
  output reg [7:0] buck_dead_time_cycles_o,
  output reg [4:0] reverse_discharge_current_limit_amps_o,
  output reg reverse_fast_response_active_o,
  output reg switching_allowed_o,
  output reg [15:0] feedback_reference_mv_o
);

  // ----------------------------------------------------------------
  // select bits
  // ----------------------------------------------------------------
  // each register answers on one bit of a one-hot select
  localparam SEL_DRIVE = 0;
  localparam SEL_DEAD = 1;
  localparam SEL_PART = 2;
  localparam SEL_DISCHARGE = 3;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one decode shared by writes and reads, so both see the same map
  function [3:0] reg_select;
    input [7:0] addr;
    begin
      reg_select = 4'h0;
      case (addr)
        `GDC_ADDR_DRIVE_STRENGTH: begin
          reg_select[SEL_DRIVE] = 1'b1;
        end
        `GDC_ADDR_DEAD_TIME: begin
          reg_select[SEL_DEAD] = 1'b1;
        end
        `GDC_ADDR_PART_ID: begin
          reg_select[SEL_PART] = 1'b1;
        end
        `GDC_ADDR_DISCHARGE: begin
          reg_select[SEL_DISCHARGE] = 1'b1;
        end
        default: begin
          reg_select = 4'h0;
        end
      endcase
    end
  endfunction

  // dead time rounded up to whole cycles so the guard is never short
  function [7:0] dead_cycles;
    input [1:0] code;
    reg [8:0] ns;
    reg [8:0] count;
    begin
      ns = {1'b0, `GDC_DEAD_TIME_BASE_NS} + {1'b0, `GDC_DEAD_TIME_STEP_NS} * {7'h00, code};
      count = (ns + {1'b0, `GDC_CLK_PERIOD_NS} - 9'h001) / {1'b0, `GDC_CLK_PERIOD_NS};
      dead_cycles = count[7:0];
    end
  endfunction

  // limit steps down from the base by a fixed amount per code
  function [4:0] discharge_amps;
    input [1:0] code;
    reg [4:0] step;
    begin
      step = `GDC_DISCHARGE_STEP_A * {3'h0, code};
      discharge_amps = `GDC_DISCHARGE_BASE_A - step;
    end
  endfunction

  // reserved bits are built as zero here, never stored
  function [7:0] pack_dead_time;
    input [3:0] fields;
    begin
      pack_dead_time = 8'h00;
      pack_dead_time[`GDC_BOOST_DEAD_MSB:`GDC_BOOST_DEAD_LSB] = fields[3:2];
      pack_dead_time[`GDC_BUCK_DEAD_MSB:`GDC_BUCK_DEAD_LSB] = fields[1:0];
    end
  endfunction

  // limit and enable sit apart, with reserved zeros between and below
  function [7:0] pack_discharge;
    input [1:0] limit;
    input fast;
    begin
      pack_discharge = 8'h00;
      pack_discharge[`GDC_LIMIT_MSB:`GDC_LIMIT_LSB] = limit;
      pack_discharge[`GDC_FAST_BIT] = fast;
    end
  endfunction

  // top bit stays zero, only part and revision fields are defined
  function [7:0] pack_part;
    input [3:0] part;
    input [2:0] rev;
    begin
      pack_part = 8'h00;
      pack_part[`GDC_PART_MSB:`GDC_PART_LSB] = part;
      pack_part[`GDC_REV_MSB:`GDC_REV_LSB] = rev;
    end
  endfunction

  // ----------------------------------------------------------------
  // registers and their next values
  // ----------------------------------------------------------------
  reg [7:0] drive_strength;
  reg [3:0] dead_time;
  reg [1:0] discharge_limit;
  reg fast_response;
  reg feedback_override;
  reg [15:0] feedback_value;
  reg [7:0] next_drive_strength;
  reg [3:0] next_dead_time;
  reg [1:0] next_discharge_limit;
  reg next_fast_response;
  reg next_feedback_override;
  reg [15:0] next_feedback_value;
  reg [7:0] next_rdata;

  wire soft_reset;
  wire [3:0] write_select;
  wire [3:0] read_select;
  wire [7:0] part_word;

  // the command clears the same fields as a hard reset, identity excepted
  assign soft_reset = reset_i | register_reset_i;
  // writes to the identity register or unmapped addresses hit no field
  assign write_select = write_i ? reg_select(addr_i) : 4'h0; // [R12] [R13]
  assign read_select = reg_select(addr_i);
  assign part_word = pack_part(PART_NUMBER, REVISION); // [R12]

  // a reset in the same cycle as a write wins, the write is lost
  always @* begin
    next_drive_strength = drive_strength;
    next_dead_time = dead_time;
    next_discharge_limit = discharge_limit;
    next_fast_response = fast_response;
    if (soft_reset) begin
      next_drive_strength = `GDC_RST_DRIVE_STRENGTH; // [R1] [R2] [R3] [R4]
      next_dead_time = `GDC_RST_DEAD_TIME; // [R5] [R6]
      next_discharge_limit = `GDC_RST_DISCHARGE_LIMIT; // [R7]
      next_fast_response = `GDC_RST_FAST_RESPONSE; // [R8]
    end else begin
      if (write_select[SEL_DRIVE]) begin
        next_drive_strength = wdata_i; // [R1] [R2] [R3] [R4]
      end
      if (write_select[SEL_DEAD]) begin
        next_dead_time[3:2] = wdata_i[`GDC_BOOST_DEAD_MSB:`GDC_BOOST_DEAD_LSB]; // [R5]
        next_dead_time[1:0] = wdata_i[`GDC_BUCK_DEAD_MSB:`GDC_BUCK_DEAD_LSB]; // [R6] [R13]
      end
      if (write_select[SEL_DISCHARGE]) begin
        next_discharge_limit = wdata_i[`GDC_LIMIT_MSB:`GDC_LIMIT_LSB]; // [R7]
        next_fast_response = wdata_i[`GDC_FAST_BIT]; // [R8] [R13]
      end
    end
  end

  // a loaded reference is dropped by either reset, the default returns
  always @* begin
    next_feedback_override = feedback_override;
    next_feedback_value = feedback_value;
    if (soft_reset) begin
      next_feedback_override = 1'b0;
      next_feedback_value = `GDC_FB_REF_DEFAULT_MV;
    end else if (feedback_reference_valid_i) begin
      next_feedback_override = 1'b1; // [R10]
      next_feedback_value = feedback_reference_setting_i;
    end
  end

  // resets live in the next values, so these flops load on every edge
  always @(posedge clk_i) begin
    drive_strength <= next_drive_strength;
    dead_time <= next_dead_time;
    discharge_limit <= next_discharge_limit;
    fast_response <= next_fast_response;
    feedback_override <= next_feedback_override;
    feedback_value <= next_feedback_value;
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // data follows the address one cycle later, unmapped addresses read zero
  always @* begin
    next_rdata = 8'h00;
    case (read_select)
      4'h1: begin
        next_rdata = drive_strength; // [R1] [R2] [R3] [R4]
      end
      4'h2: begin
        next_rdata = pack_dead_time(dead_time); // [R13]
      end
      4'h4: begin
        next_rdata = part_word; // [R12]
      end
      4'h8: begin
        next_rdata = pack_discharge(discharge_limit, fast_response); // [R13]
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // outputs to the power stage
  // ----------------------------------------------------------------
  reg [1:0] next_boost_high_side_drive_strength;
  reg [1:0] next_buck_high_side_drive_strength;
  reg [1:0] next_boost_low_side_drive_strength;
  reg [1:0] next_buck_low_side_drive_strength;
  reg [7:0] next_boost_dead_time_cycles;
  reg [7:0] next_buck_dead_time_cycles;
  reg [4:0] next_reverse_discharge_current_limit_amps;
  reg next_reverse_fast_response_active;
  reg next_switching_allowed;
  reg [15:0] next_feedback_reference_mv;
  wire input_in_window;

  // either sense tripping drops switching on the next clock edge, no filtering or hysteresis
  assign input_in_window = ~input_undervoltage_sense_i & ~input_overvoltage_sense_i; // [R9]

  always @* begin
    next_boost_high_side_drive_strength =
      drive_strength[`GDC_BOOST_HIGH_MSB:`GDC_BOOST_HIGH_LSB]; // [R1]
    next_buck_high_side_drive_strength =
      drive_strength[`GDC_BUCK_HIGH_MSB:`GDC_BUCK_HIGH_LSB]; // [R2]
    next_boost_low_side_drive_strength =
      drive_strength[`GDC_BOOST_LOW_MSB:`GDC_BOOST_LOW_LSB]; // [R3]
    next_buck_low_side_drive_strength =
      drive_strength[`GDC_BUCK_LOW_MSB:`GDC_BUCK_LOW_LSB]; // [R4]
    next_boost_dead_time_cycles = dead_cycles(dead_time[3:2]); // [R5]
    next_buck_dead_time_cycles = dead_cycles(dead_time[1:0]); // [R6]
    next_reverse_discharge_current_limit_amps = discharge_amps(discharge_limit); // [R7]
    // the enable is kept while forward, it only acts in reverse mode
    next_reverse_fast_response_active = fast_response & reverse_mode_i; // [R8]
    next_switching_allowed = input_in_window; // [R9]
    if (feedback_override) begin
      next_feedback_reference_mv = feedback_value; // [R10]
    end else begin
      next_feedback_reference_mv = `GDC_FB_REF_DEFAULT_MV; // [R10]
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      boost_high_side_drive_strength_o <= 2'h0;
      buck_high_side_drive_strength_o <= 2'h0;
      boost_low_side_drive_strength_o <= 2'h0;
      buck_low_side_drive_strength_o <= 2'h0;
      boost_dead_time_cycles_o <= 8'h00;
      buck_dead_time_cycles_o <= 8'h00;
      reverse_discharge_current_limit_amps_o <= 5'h00;
      reverse_fast_response_active_o <= 1'b0;
      switching_allowed_o <= 1'b0;
      feedback_reference_mv_o <= `GDC_FB_REF_DEFAULT_MV;
    end else begin
      boost_high_side_drive_strength_o <= next_boost_high_side_drive_strength;
      buck_high_side_drive_strength_o <= next_buck_high_side_drive_strength;
      boost_low_side_drive_strength_o <= next_boost_low_side_drive_strength;
      buck_low_side_drive_strength_o <= next_buck_low_side_drive_strength;
      boost_dead_time_cycles_o <= next_boost_dead_time_cycles;
      buck_dead_time_cycles_o <= next_buck_dead_time_cycles;
      reverse_discharge_current_limit_amps_o <= next_reverse_discharge_current_limit_amps;
      reverse_fast_response_active_o <= next_reverse_fast_response_active;
      switching_allowed_o <= next_switching_allowed;
      feedback_reference_mv_o <= next_feedback_reference_mv;
    end
  end

endmodule
`default_nettype wire

// [shared/gdc_regs.vh]
// register offsets, field positions and reset values for the gate drive config bank
`ifndef GDC_REGS_VH
`define GDC_REGS_VH
`define GDC_ADDR_DRIVE_STRENGTH 8'h3B
`define GDC_ADDR_DEAD_TIME 8'h3C
`define GDC_ADDR_PART_ID 8'h3D
`define GDC_ADDR_DISCHARGE 8'h62
`define GDC_RST_DRIVE_STRENGTH 8'h00
`define GDC_RST_DEAD_TIME 4'h0
`define GDC_RST_DISCHARGE_LIMIT 2'h0
`define GDC_RST_FAST_RESPONSE 1'h1
`define GDC_DEAD_TIME_BASE_NS 8'h2D
`define GDC_DEAD_TIME_STEP_NS 8'h1E
`define GDC_CLK_PERIOD_NS 8'h04
`define GDC_DISCHARGE_BASE_A 5'h14
`define GDC_DISCHARGE_STEP_A 5'h05
`define GDC_FB_REF_DEFAULT_MV 16'h0600
`define GDC_BOOST_HIGH_MSB 7
`define GDC_BOOST_HIGH_LSB 6
`define GDC_BUCK_HIGH_MSB 5
`define GDC_BUCK_HIGH_LSB 4
`define GDC_BOOST_LOW_MSB 3
`define GDC_BOOST_LOW_LSB 2
`define GDC_BUCK_LOW_MSB 1
`define GDC_BUCK_LOW_LSB 0
`define GDC_BOOST_DEAD_MSB 3
`define GDC_BOOST_DEAD_LSB 2
`define GDC_BUCK_DEAD_MSB 1
`define GDC_BUCK_DEAD_LSB 0
`define GDC_LIMIT_MSB 7
`define GDC_LIMIT_LSB 6
`define GDC_FAST_BIT 1
`define GDC_PART_MSB 6
`define GDC_PART_LSB 3
`define GDC_REV_MSB 2
`define GDC_REV_LSB 0
`endif

// [sim/gdc_checker.sv]
// concurrent checks on the gate drive config bank ports
`timescale 1ns/1ps
`default_nettype none
// ----
// checker
// ----
module gdc_checker (
  input wire clk_i, reset_i, register_reset_i, write_i, reverse_mode_i,
  input wire feedback_reference_valid_i, input_undervoltage_sense_i, input_overvoltage_sense_i,
  input wire [7:0] addr_i, rdata_o, boost_dead_time_cycles_o, buck_dead_time_cycles_o,
  input wire [1:0] boost_high_side_drive_strength_o, buck_high_side_drive_strength_o,
  input wire [1:0] boost_low_side_drive_strength_o, buck_low_side_drive_strength_o,
  input wire [4:0] reverse_discharge_current_limit_amps_o,
  input wire reverse_fast_response_active_o, switching_allowed_o,
  input wire [15:0] feedback_reference_mv_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // rounded up so the gap is never shorter than asked
  function automatic [7:0] dt(input [1:0] c);
    dt = (8'h1E * c + 8'h30) >> 2;
  endfunction
  property p_drive; addr_i == 8'h3B |=> rdata_o == {boost_high_side_drive_strength_o,
    buck_high_side_drive_strength_o, boost_low_side_drive_strength_o,
    buck_low_side_drive_strength_o}; endproperty
  a_drive: assert property (p_drive) else $error("drive mismatch");
  property p_dead; addr_i == 8'h3C |=> rdata_o[7:4] == 4'h0 &&
    boost_dead_time_cycles_o == dt(rdata_o[3:2]) && buck_dead_time_cycles_o == dt(rdata_o[1:0]);
  endproperty
  a_dead: assert property (p_dead) else $error("dead time mismatch");
  property p_limit; addr_i == 8'h62 |=> {rdata_o[5:2], rdata_o[0]} == 5'h00 &&
    reverse_discharge_current_limit_amps_o == 5'h14 - 5'h05 * rdata_o[7:6]; endproperty
  a_limit: assert property (p_limit) else $error("limit mismatch");
  property p_fast; addr_i == 8'h62 |=>
    reverse_fast_response_active_o == (rdata_o[1] && $past(reverse_mode_i)); endproperty
  a_fast: assert property (p_fast) else $error("fast response mismatch");
  property p_sw; 1'h1 |=> switching_allowed_o ==
    !$past(input_undervoltage_sense_i || input_overvoltage_sense_i); endproperty
  a_sw: assert property (p_sw) else $error("switching mismatch");
  property p_fb; register_reset_i && !feedback_reference_valid_i ##1
    !feedback_reference_valid_i |=> feedback_reference_mv_o == 16'h0600; endproperty
  a_fb: assert property (p_fb) else $error("reference mismatch");
  // identity value follows the arbitrary part and revision parameters
  property p_id; addr_i == 8'h3D |=> rdata_o == 8'h29; endproperty
  a_id: assert property (p_id) else $error("id mismatch");
  property p_rr; register_reset_i ##1 !write_i |=>
    reverse_discharge_current_limit_amps_o == 5'h14 && boost_dead_time_cycles_o == 8'h0C;
  endproperty
  a_rr: assert property (p_rr) else $error("defaults mismatch");
endmodule
bind gdc_gate_drive_config gdc_checker u_chk (.*);
`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench for the gate drive config bank
`timescale 1ns/1ps
`default_nettype none
// ----
// bench
// ----
module tb_top;
  logic clk_i = '0, reset_i = '1, register_reset_i = '0, write_i = '0, reverse_mode_i = '0;
  logic input_undervoltage_sense_i = '0, input_overvoltage_sense_i = '0;
  logic feedback_reference_valid_i = '0;
  logic [7:0] addr_i = '0, wdata_i = '0;
  logic [15:0] feedback_reference_setting_i = '0;
  wire [7:0] rdata_o, boost_dead_time_cycles_o, buck_dead_time_cycles_o;
  wire [1:0] boost_high_side_drive_strength_o, buck_high_side_drive_strength_o;
  wire [1:0] boost_low_side_drive_strength_o, buck_low_side_drive_strength_o;
  wire [4:0] reverse_discharge_current_limit_amps_o;
  wire reverse_fast_response_active_o, switching_allowed_o;
  wire [15:0] feedback_reference_mv_o;
  // 45/75/105/135 ns rounded up to 4 ns cycles
  logic [7:0] dt [4] = '{8'h0C, 8'h13, 8'h1B, 8'h22};
  int errors = 0, checked = 0, cycles = 0;
  gdc_gate_drive_config u_dut (.*);
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      errors = errors + 1;
      end_sim();
    end
  end
  task automatic chk(input [15:0] s, e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input [7:0] a, d);
    addr_i = a;
    wdata_i = d;
    write_i = 1'h1;
    @(posedge clk_i) #1;
    write_i = 1'h0;
  endtask
  task automatic rd(input [7:0] a, e);
    addr_i = a;
    @(posedge clk_i) #1;
    chk(rdata_o, e);
  endtask
  task automatic end_sim;
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    #1 reset_i = 1'h0;
    rd(8'h3C, 8'h00);
    rd(8'h62, 8'h02);
    rd(8'h10, 8'h00);
    chk(feedback_reference_mv_o, 16'h0600);
    wr(8'h3D, 8'hFF);
    rd(8'h3D, 8'h29);
    wr(8'h3B, 8'hE4);
    rd(8'h3B, 8'hE4);
    chk({boost_high_side_drive_strength_o, buck_high_side_drive_strength_o,
      boost_low_side_drive_strength_o, buck_low_side_drive_strength_o}, 16'h00E4);
    reverse_mode_i = 1'h1;
    for (int c = 0; c < 4; c++) begin
      wr(8'h3C, {4'hF, c[1:0], ~c[1:0]});
      rd(8'h3C, {4'h0, c[1:0], ~c[1:0]});
      chk(boost_dead_time_cycles_o, dt[c]);
      chk(buck_dead_time_cycles_o, dt[3-c]);
      wr(8'h62, {c[1:0], 6'h3F});
      rd(8'h62, {c[1:0], 6'h02});
      chk(reverse_discharge_current_limit_amps_o, 20 - 5 * c);
      chk(reverse_fast_response_active_o, 16'h0001);
    end
    reverse_mode_i = 1'h0;
    @(posedge clk_i) #1;
    chk(reverse_fast_response_active_o, 16'h0000);
    reverse_mode_i = 1'h1;
    wr(8'h62, 8'h00);
    rd(8'h62, 8'h00);
    chk(reverse_fast_response_active_o, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      {input_undervoltage_sense_i, input_overvoltage_sense_i} = i[1:0];
      @(posedge clk_i) #1;
      chk(switching_allowed_o, i == 0);
    end
    feedback_reference_setting_i = 16'h05F8;
    feedback_reference_valid_i = 1'h1;
    @(posedge clk_i) #1;
    feedback_reference_valid_i = 1'h0;
    @(posedge clk_i) #1;
    chk(feedback_reference_mv_o, 16'h05F8);
    register_reset_i = 1'h1;
    @(posedge clk_i) #1;
    register_reset_i = 1'h0;
    rd(8'h3B, 8'h00);
    rd(8'h62, 8'h02);
    chk(feedback_reference_mv_o, 16'h0600);
    end_sim();
  end
endmodule
`default_nettype wire
